// file: logic/coef_ctrl.v
// Link training coefficient update, status and measurement window registers
//
// Chosen here: the Wishbone register port.
`timescale 1ns/100ps
`include "coef_ctrl_regs.vh"
// What this block does
// - Low window field counts frames when thousands and millions zero
// - Low field resets 3 simulation, 0 hardware
// - Bits 19:10 count thousands of frames
// - Thousands field resets 0 simulation, F hardware
// - Bits 29:20 count millions of frames
// - Millions field resets to zero
// - Bits 5:0 mirror first transmitted control word
// - Update bits writable only while override set
// - Update codes: hold, increment, decrement, reserved
// - Bit 6 requests partner initialize state
// - Bit 7 requests partner preset, equalization off
// - Bits 13:8 report second transmitted word
module coef_ctrl
#(
   parameter SIM_BUILD = 0                 // 1 selects simulation reset values
)
(
   input  wire        clk_i,               // System clock, 100 MHz
   input  wire        rst_i,               // Synchronous reset, active high
   input  wire        wb_cyc_i,            // Wishbone cycle
   input  wire        wb_stb_i,            // Wishbone strobe
   input  wire        wb_we_i,             // Wishbone write enable
   input  wire [9:0]  wb_adr_i,            // Wishbone byte address
   input  wire [3:0]  wb_sel_i,            // Wishbone byte selects
   input  wire [31:0] wb_dat_i,            // Wishbone write data
   output reg  [31:0] wb_dat_o,            // Wishbone read data
   output wire        wb_ack_o,            // Wishbone acknowledge
   input  wire [5:0]  train_update_i,      // Update word from training logic
   input  wire        train_init_i,        // Initialize request from training logic
   input  wire        train_preset_i,      // Preset request from training logic
   input  wire [5:0]  tx_status_i,         // Second word of frame being sent
   input  wire        frame_sent_i,        // Pulse per transmitted frame
   input  wire        step_start_i,        // Pulse at start of equalization step
   output reg  [5:0]  local_coef_update_field, // First word update bits sent
   output reg         request_partner_init,    // Initialize bit sent
   output reg         request_partner_preset,  // Preset bit sent
   output wire [39:0] step_length_o,       // Frames per equalization step
   output wire        step_busy_o,         // Measurement step running
   output wire        step_done_o          // Pulse at end of measurement step
);
   // Window fields, override state, status capture and bus state
   reg  [9:0]  win_low;                    // Plain frame count field
   reg  [9:0]  win_k;                      // Thousands of frames field
   reg  [9:0]  win_m;                      // Millions of frames field
   reg         ovr_en;                     // Coefficient override enable
   reg  [5:0]  ovr_update;                 // Software update bits
   reg         ovr_init;                   // Software initialize bit
   reg         ovr_preset;                 // Software preset bit
   reg  [5:0]  local_coef_status_field;    // Last sent status word
   reg         done_seen;                  // Sticky step-done flag
   reg         ack;                        // Registered acknowledge
   wire        req;                        // Bus request pending
   wire        wr;                         // Write taking effect
   wire [7:0]  idx;                        // Word index
   wire [31:0] wmask;                      // Byte lane mask
   wire [31:0] win_word;                   // Window register image
   wire [31:0] coef_word;                  // Coefficient register image
   wire [31:0] next_win;                   // Window register after write
   wire [31:0] next_coef;                  // Coefficient register after write
   reg  [39:0] step_len;                   // Registered frames per step

   // Expand byte selects into a bit mask
   // Lane 0 covers bits 7:0 and lane 3 bits 31:24
   function [31:0] lane_mask;
      input [3:0] sel;
      begin
         lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
      end
   endfunction

   // Merge write data into an old word under a mask
   // Bits outside the mask keep their old value
   function [31:0] merge;
      input [31:0] old;
      input [31:0] dat;
      input [31:0] mask;
      begin
         merge = (old & ~mask) | (dat & mask);
      end
   endfunction

   // Replace reserved update code by hold so it is never sent
   // Checked per tap: bits 5:4, 3:2 and 1:0
   function [5:0] clean_update;
      input [5:0] upd;
      integer     t;
      begin
         clean_update = upd;
         for (t = 0; t < 3; t = t + 1)
         begin
            if (upd[2*t +: 2] == `UPD_RSVD)
               clean_update[2*t +: 2] = `UPD_HOLD;
         end
      end
   endfunction

   // Frames per step from the three window fields; the plain count only
   // applies while both scaled fields are zero, so a stale low value
   // never adds to a scaled length
   function [39:0] step_frames;
      input [9:0] m;                       // Millions of frames
      input [9:0] k;                       // Thousands of frames
      input [9:0] low;                     // Plain frame count
      begin
         if ((m == 10'h000) && (k == 10'h000))
            step_frames = {30'h00000000, low};
         else
            step_frames = ({30'h00000000, m} * {20'h00000, `FRAMES_PER_M}) +
                          ({30'h00000000, k} * {20'h00000, `FRAMES_PER_K});
      end
   endfunction

   // Bus decode and register images
   assign req       = wb_cyc_i & wb_stb_i;
   assign wb_ack_o  = ack;
   assign wr        = req & wb_we_i & ~ack;
   assign idx       = wb_adr_i[9:2];
   assign wmask     = lane_mask(wb_sel_i);
   assign win_word  = {2'b00, win_m, win_k, win_low};
   assign coef_word = {18'h00000, local_coef_status_field,
                       request_partner_preset, request_partner_init,
                       local_coef_update_field};
   assign next_win  = merge(win_word, wb_dat_i, wmask);
   assign next_coef = merge(coef_word, wb_dat_i, wmask);

   // Step length is registered so the counter and the pin see a settled
   // value one cycle after a window write
   assign step_length_o = step_len;

   // Length register; out of reset it already matches the reset fields
   always @(posedge clk_i)
   begin
      if (rst_i)
         step_len <= step_frames(`RST_M,
                                 SIM_BUILD ? `RST_K_SIM : `RST_K_HW,
                                 SIM_BUILD ? `RST_LOW_SIM : `RST_LOW_HW);
      else
         step_len <= step_frames(win_m, win_k, win_low);
   end

   // Acknowledge one cycle after each request, dropped the cycle after
   // Ack high gates the write, so a request that the master still holds
   // at the ack edge is not taken a second time
   // A request still held after the ack cycle is taken again as a new one
   always @(posedge clk_i)
   begin
      if (rst_i)
         ack <= 1'b0;
      else
         ack <= req & ~ack;
   end

   // Measurement window register with build-dependent reset values
   // Simulation builds start with a short window so a step ends quickly;
   // hardware builds start with fifteen thousand frames per step
   // A new length applies one cycle after the write, also to a running step
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         win_low <= SIM_BUILD ? `RST_LOW_SIM : `RST_LOW_HW;
         win_k   <= SIM_BUILD ? `RST_K_SIM : `RST_K_HW;
         win_m   <= `RST_M;
      end
      // Byte lanes merge into the old image; a partial write keeps the rest
      else if (wr && idx == `IDX_WINDOW)
      begin
         win_low <= next_win[`WIN_LOW_MSB:`WIN_LOW_LSB];
         win_k   <= next_win[`WIN_K_MSB:`WIN_K_LSB];
         win_m   <= next_win[`WIN_M_MSB:`WIN_M_LSB];
      end
   end

   // Override control and software coefficient bits
   // Override enable sits on its own control word so software turns it on
   // before writing coefficients; coefficient writes are dropped while off
   // The software bits keep their value when override is turned off
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ovr_en     <= 1'b0;
         ovr_update <= 6'h00;
         ovr_init   <= 1'b0;
         ovr_preset <= 1'b0;
      end
      else if (wr)
      begin
         if (idx == `IDX_CTRL)
         begin
            // Override enable on its own control word
            if (wb_sel_i[0])
               ovr_en <= wb_dat_i[`CTRL_OVR_BIT];
         end
         else if (idx == `IDX_COEF && ovr_en)
         begin
            // Writes land only while override is on
            ovr_update <= next_coef[`COEF_UPD_MSB:`COEF_UPD_LSB];
            ovr_init   <= next_coef[`COEF_INIT_BIT];
            ovr_preset <= next_coef[`COEF_PRESET_BIT];
         end
      end
   end

   // Bits sent in the first control word of each frame
   // One cycle of latency from either source; reserved update codes are
   // sent as hold so the partner never sees an undefined request
   // Switching the source takes effect on the cycle after the control write
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         local_coef_update_field <= 6'h00;
         request_partner_init    <= 1'b0;
         request_partner_preset  <= 1'b0;
      end
      else if (ovr_en)
      begin
         // Software values are transmitted
         local_coef_update_field <= clean_update(ovr_update);
         request_partner_init    <= ovr_init;
         request_partner_preset  <= ovr_preset;
      end
      else
      begin
         // Mirror what training logic sends
         local_coef_update_field <= clean_update(train_update_i);
         request_partner_init    <= train_init_i;
         request_partner_preset  <= train_preset_i;
      end
   end

   // Capture the status word of each transmitted frame
   // Only a frame pulse loads the field, so it keeps the last frame's word
   // between frames and while frames stop
   // Software writes never reach this field
   always @(posedge clk_i)
   begin
      if (rst_i)
         local_coef_status_field <= 6'h00;
      else if (frame_sent_i)
         local_coef_status_field <= tx_status_i;
   end

   // Sticky step-done flag; a new event beats a clearing write
   // Software clears it by writing one to bit 0; an end of step in the
   // same cycle keeps it set, so no step end is ever lost
   // Writing zero leaves the flag as it is
   always @(posedge clk_i)
   begin
      if (rst_i)
         done_seen <= 1'b0;
      else if (step_done_o)
         done_seen <= 1'b1;
      else if (wr && idx == `IDX_STATUS && wb_sel_i[0] && wb_dat_i[`STAT_DONE_BIT])
         done_seen <= 1'b0;
   end

   // Read data multiplexer; unmapped words read as zero
   // Data loads on the edge that takes the request and then stands with
   // ack and until the next request
   // A read of the coefficient word shows the bits as they are sent
   always @(posedge clk_i)
   begin
      if (rst_i)
         wb_dat_o <= 32'h00000000;
      // Load only on the taking edge, never on the ack edge
      else if (req && !ack)
      begin
         if (idx == `IDX_WINDOW)
            wb_dat_o <= win_word;
         else if (idx == `IDX_COEF)
            wb_dat_o <= coef_word;
         else if (idx == `IDX_CTRL)
            wb_dat_o <= {31'h00000000, ovr_en};
         else if (idx == `IDX_STATUS)
            wb_dat_o <= {30'h00000000, step_busy_o, done_seen};
         else
            wb_dat_o <= 32'h00000000;
      end
   end

   // Frame counter for the measurement step
   // It restarts on every step start pulse and ends the step after the
   // registered length in frames
   // A zero length ends the step at the first frame
   frame_step_counter u_counter
   (
      .clk_i    (clk_i),
      .rst_i    (rst_i),
      .start_i  (step_start_i),
      .frame_i  (frame_sent_i),
      .length_i (step_length_o),
      .busy_o   (step_busy_o),
      .done_o   (step_done_o)
   );
endmodule

// file: logic/coef_ctrl_regs.vh
// Register offsets, field positions, reset values and codes of the coefficient control block
`ifndef COEF_CTRL_REGS_VH
`define COEF_CTRL_REGS_VH
// Word indices as printed; byte address is four times the index
`define IDX_WINDOW          8'hD3
`define IDX_COEF            8'hD4
`define IDX_CTRL            8'hD0
`define IDX_STATUS          8'hD2
// Measurement window fields
`define WIN_LOW_LSB         0
`define WIN_LOW_MSB         9
`define WIN_K_LSB           10
`define WIN_K_MSB           19
`define WIN_M_LSB           20
`define WIN_M_MSB           29
`define RST_LOW_SIM         10'h003
`define RST_LOW_HW          10'h000
`define RST_K_SIM           10'h000
`define RST_K_HW            10'h00F
`define RST_M               10'h000
// Coefficient register fields
`define COEF_UPD_LSB        0
`define COEF_UPD_MSB        5
`define COEF_INIT_BIT       6
`define COEF_PRESET_BIT     7
`define COEF_STAT_LSB       8
`define COEF_STAT_MSB       13
// Control register field: coefficient override enable
`define CTRL_OVR_BIT        0
// Status register field: measurement step done sticky
`define STAT_DONE_BIT       0
// Update codes per tap
`define UPD_HOLD            2'h0
`define UPD_INC             2'h1
`define UPD_DEC             2'h2
`define UPD_RSVD            2'h3
// Status codes per tap
`define ST_NOT_UPD          2'h0
`define ST_UPDATED          2'h1
`define ST_MIN              2'h2
`define ST_MAX              2'h3
`define FRAMES_PER_K        20'h003E8
`define FRAMES_PER_M        20'hF4240
`endif

// file: logic/frame_step_counter.v
// Counter of training frames examined during one equalization step
`timescale 1ns/100ps
module frame_step_counter
(
   input  wire        clk_i,      // System clock
   input  wire        rst_i,      // Synchronous reset, active high
   input  wire        start_i,    // Begin a new step
   input  wire        frame_i,    // One training frame sent
   input  wire [39:0] length_i,   // Frames per step
   output reg         busy_o,     // Step in progress
   output reg         done_o      // Pulse when step length reached
);
   reg [39:0] count;              // Frames seen in this step

   // Count frames until the step length is reached
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         count  <= 40'h0000000000;
         busy_o <= 1'b0;
         done_o <= 1'b0;
      end
      else
      begin
         done_o <= 1'b0;
         if (start_i)
         begin
            // Restart the step
            count  <= 40'h0000000000;
            busy_o <= 1'b1;
         end
         else if (busy_o && frame_i)
         begin
            // Last frame ends the step; a zero length ends at first frame
            if (count + 40'h0000000001 >= length_i)
            begin
               busy_o <= 1'b0;
               done_o <= 1'b1;
            end
            count <= count + 40'h0000000001;
         end
      end
   end
endmodule

// file: verif/coef_ctrl_asserts.sv
// Port-level checks of the coefficient control block
`timescale 1ns/100ps
`include "coef_ctrl_regs.vh"
module coef_ctrl_asserts
(
   input  wire logic        clk_i,                   // Clock
   input  wire logic        rst_i,                   // Reset
   input  wire logic        wb_cyc_i,                // Cycle
   input  wire logic        wb_stb_i,                // Strobe
   input  wire logic        wb_we_i,                 // Write
   input  wire logic [9:0]  wb_adr_i,                // Address
   input  wire logic [3:0]  wb_sel_i,                // Lanes
   input  wire logic [31:0] wb_dat_i,                // Write data
   input  wire logic [31:0] wb_dat_o,                // Read data
   input  wire logic        wb_ack_o,                // Ack
   input  wire logic [5:0]  train_update_i,          // Training update
   input  wire logic        train_init_i,            // Training init
   input  wire logic        train_preset_i,          // Training preset
   input  wire logic [5:0]  local_coef_update_field, // Sent update
   input  wire logic        request_partner_init,    // Sent init
   input  wire logic        request_partner_preset,  // Sent preset
   input  wire logic        step_done_o              // Step end
);
   logic ovr;                                          // Override shadow
   wire  tk = wb_cyc_i && wb_stb_i && !wb_ack_o;       // Request taken
   wire  cw = tk && wb_we_i && wb_adr_i[9:2] == `IDX_COEF;  // Coef write
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // Follow override enable as software writes it
   always @(posedge clk_i)
   begin
      if (rst_i)
         ovr <= 1'b0;
      else if (tk && wb_we_i && wb_adr_i[9:2] == `IDX_CTRL && wb_sel_i[0])
         ovr <= wb_dat_i[0];
   end
   a_ack_next: assert property (tk |=> wb_ack_o) else $error("ack late");
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack long");
   a_upd_follow: assert property (!ovr |=> local_coef_update_field == $past(train_update_i))
      else $error("update bits not mirrored");
   a_init_follow: assert property (!ovr |=> request_partner_init == $past(train_init_i))
      else $error("init not mirrored");
   a_preset_follow: assert property (!ovr |=> request_partner_preset == $past(train_preset_i))
      else $error("preset not mirrored");
   a_ovr_hold: assert property ((ovr && !cw) ##1 (ovr && !cw) |=>
      $stable({local_coef_update_field, request_partner_init, request_partner_preset}))
      else $error("override bits moved");
   a_done_pulse: assert property (step_done_o |=> !step_done_o) else $error("done long");
   a_unmapped_zero: assert property (tk && !wb_we_i && !(wb_adr_i[9:2] inside
      {`IDX_CTRL, `IDX_STATUS, `IDX_WINDOW, `IDX_COEF}) |=> wb_dat_o == 32'h00000000)
      else $error("unmapped read not zero");
   a_coef_read: assert property (tk && !wb_we_i && wb_adr_i[9:2] == `IDX_COEF |=>
      wb_dat_o[7:0] == $past({request_partner_preset, request_partner_init,
      local_coef_update_field})) else $error("coef read differs");
endmodule
bind coef_ctrl coef_ctrl_asserts i_coef_ctrl_asserts (.*);

// file: verif/train_partner.sv
// Model of the training logic feeding the block
`timescale 1ns/100ps
module train_partner
(
   input  wire logic       clk_i,    // Clock
   input  wire logic       rst_i,    // Reset
   input  wire logic       en_i,     // Frames flow
   output logic      [5:0] upd_o,    // First word update
   output logic            init_o,   // Init request
   output logic            preset_o, // Preset request
   output logic      [5:0] st_o,     // Second word
   output logic            frame_o   // Frame pulse
);
   logic [1:0] cnt;                  // Frame spacing
   // One frame every four cycles with fresh words
   always @(posedge clk_i)
   begin
      frame_o <= 1'b0;
      if (rst_i)
      begin
         cnt <= 2'h0;
         {upd_o, init_o, preset_o, st_o} <= 14'h0000;
      end
      else if (en_i)
      begin
         cnt <= cnt + 2'h1;
         if (cnt == 2'h3)
         begin
            frame_o <= 1'b1;
            upd_o <= {2'($urandom % 3), 2'($urandom % 3), 2'($urandom % 3)};
            {init_o, preset_o} <= 2'($urandom);
            st_o <= 6'($urandom);
         end
      end
   end
endmodule

// file: verif/coef_ctrl_tb_top.sv
// Self-checking bench of the coefficient control block
`timescale 1ns/100ps
module coef_ctrl_tb_top;
   logic        clk_i = 1'b0, rst_i = 1'b1;          // Clock, reset
   logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;   // Bus request
   logic        go = 1'b0, en = 1'b1;                // Step start, frames on
   logic [3:0]  sel = 4'hF, nsel = 4'hF;             // Lanes driven, lanes wanted
   logic [9:0]  adr = 10'h000, lo, k, mm;            // Address, fields
   logic [31:0] dat = 32'h00000000, ee, em;          // Write data, note
   logic [31:0] eq[$], mq[$];                        // Expected reads
   logic [39:0] ln;                                  // Expected length
   logic [5:0]  last_st, tu, ts, upd;                // Status and words
   logic [1:0]  c;                                   // Code under test
   wire  [31:0] rdat;                                // Read data
   wire  [39:0] len;                                 // Step length
   wire         ack, ti, tp, fr, init, pre, busy, done;
   int          mismatches = 0, total_checks = 0, n, i, fc;
   always #5 clk_i = ~clk_i;
   coef_ctrl #(.SIM_BUILD(1)) i_coef_ctrl (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .train_update_i(tu), .train_init_i(ti),
      .train_preset_i(tp), .tx_status_i(ts), .frame_sent_i(fr), .step_start_i(go),
      .local_coef_update_field(upd), .request_partner_init(init),
      .request_partner_preset(pre), .step_length_o(len), .step_busy_o(busy),
      .step_done_o(done));
   train_partner i_train_partner (.clk_i(clk_i), .rst_i(rst_i), .en_i(en), .upd_o(tu),
      .init_o(ti), .preset_o(tp), .st_o(ts), .frame_o(fr));
   // Compare and count
   task chk(input string nm, input logic [39:0] s, input logic [39:0] e);
      begin
         total_checks++;
         if (s !== e)
         begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
         end
      end
   endtask
   // Report counts and end the run
   task give_verdict;
      begin
         $display("checks %0d mismatches %0d", total_checks, mismatches);
         if (mismatches == 0 && total_checks > 0)
            $display("Regression OK");
         else
            $display("Regression broken");
         $finish;
      end
   endtask
   // One classic bus cycle; a read notes its expected value and mask
   task wb(input logic w, input logic [9:0] a, input logic [31:0] d, input logic [31:0] m);
      int t;
      begin
         if (!w)
         begin
            eq.push_back(d);
            mq.push_back(m);
         end
         @(posedge clk_i);
         {cyc, stb, we, adr, dat, sel} <= {2'h3, w, a, d, nsel};
         t = 0;
         do
         begin
            @(posedge clk_i);
            t++;
         end
         while (ack !== 1'b1 && t < 50);
         {cyc, stb} <= 2'h0;
         if (ack !== 1'b1)
         begin
            mismatches++;
            give_verdict;
         end
      end
   endtask
   // Read answers checked against the oldest note
   always @(posedge clk_i)
   begin
      if (ack === 1'b1 && we === 1'b0 && eq.size() > 0)
      begin
         em = mq.pop_front();
         ee = eq.pop_front();
         chk("read data", rdat & em, ee & em);
      end
      if (fr === 1'b1)
         last_st <= ts;
   end
   // Main sequence
   initial
   begin
      n = $urandom(32);
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(0, 10'h34C, 32'h00000003, 32'h3FFFFFFF);
      chk("reset length", len, 40'h0000000003);
      $display("test reset done");
      for (i = 0; i < 3; i++)
      begin
         lo = 10'($urandom);
         k = (i == 1) ? 10'h3E8 : (i == 0) ? 10'($urandom) : 10'h000;
         mm = (i == 1) ? 10'($urandom) : 10'h000;
         wb(1, 10'h34C, {2'h0, mm, k, lo}, 32'h00000000);
         wb(0, 10'h34C, {2'h0, mm, k, lo}, 32'h3FFFFFFF);
         ln = (mm == 0 && k == 0) ? 40'(lo) : 40'(mm) * 40'hF4240 + 40'(k) * 40'h3E8;
         chk("step length", len, ln);
      end
      nsel = 4'h2;
      wb(1, 10'h34C, 32'hFFFFFFFF, 32'h00000000);
      nsel = 4'hF;
      wb(0, 10'h34C, {16'h0000, 8'hFF, lo[7:0]}, 32'h3FFFFFFF);
      $display("test window done");
      wb(1, 10'h34C, 32'h00000003, 32'h00000000);
      n = 0;
      do @(posedge clk_i); while (fr !== 1'b1 && ++n < 20);
      if (fr !== 1'b1)
      begin
         mismatches++;
         give_verdict;
      end
      go <= 1'b1;
      @(posedge clk_i);
      go <= 1'b0;
      fc = 0;
      for (n = 0; n < 100 && done !== 1'b1; n++)
      begin
         fc += (fr === 1'b1);
         @(posedge clk_i);
      end
      if (done !== 1'b1)
      begin
         mismatches++;
         give_verdict;
      end
      chk("frames per step", fc, 3);
      chk("step busy", busy, 1'b0);
      wb(0, 10'h348, 32'h00000001, 32'h00000003);
      wb(1, 10'h348, 32'h00000001, 32'h00000000);
      wb(0, 10'h348, 32'h00000000, 32'h00000003);
      $display("test step done");
      wb(1, 10'h350, 32'h000000FF, 32'h00000000);
      wb(1, 10'h340, 32'h00000001, 32'h00000000);
      @(posedge clk_i);
      chk("refused write", {pre, init, upd}, 8'h00);
      for (i = 0; i < 4; i++)
      begin
         c = i[1:0];
         wb(1, 10'h350, {24'h000000, c, c, c, c}, 32'h00000000);
         @(posedge clk_i);
         chk("update bits", upd, (c == 2'h3) ? 6'h00 : {c, c, c});
         chk("init and preset", {pre, init}, c);
         wb(0, 10'h350, {24'h000000, c, (c == 2'h3) ? 6'h00 : {c, c, c}}, 32'h000000FF);
      end
      $display("test override done");
      en <= 1'b0;
      repeat (4) @(posedge clk_i);
      wb(1, 10'h350, {18'h00000, ~last_st, 8'h00}, 32'h00000000);
      wb(0, 10'h350, {18'h00000, last_st, 8'h00}, 32'h00003F00);
      en <= 1'b1;
      wb(1, 10'h3FC, 32'hFFFFFFFF, 32'h00000000);
      wb(0, 10'h3FC, 32'h00000000, 32'hFFFFFFFF);
      wb(1, 10'h340, 32'h00000000, 32'h00000000);
      repeat (20) @(posedge clk_i);
      $display("test status done");
      give_verdict;
   end
endmodule
